// ### pkg/rbm_pkg.sv
// Shared constants and types for the reset, boot mode and pin bank block
package rbm_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 4;

  // ==========================================================
  // Reset request qualification
  localparam int unsigned   QUAL_CYC     = 3;
  localparam logic [1:0]    QUAL_CNT_MAX = 2'(QUAL_CYC - 1);
  localparam logic [1:0]    SYNC_RST     = 2'h3;

  // ==========================================================
  // Reset output stretch and boot latch
  localparam logic [2:0]    STRETCH_CYC   = 3'h7;
  localparam int unsigned   BOOT_LEAD_CYC = 3;
  localparam logic [2:0]    BOOT_CAP_CNT  = 3'(BOOT_LEAD_CYC + 1);
  localparam logic [2:0]    CNT_LAST      = 3'h1;
  localparam logic          BOOT_RST      = 1'h0;
  localparam logic          STO_RST       = 1'h0;

  // ==========================================================
  // Shared pin bank, alternate order
  localparam int unsigned   NPIN        = 8;
  localparam int unsigned   PIN_TRST    = 0;
  localparam int unsigned   PIN_TMS     = 1;
  localparam int unsigned   PIN_DSP_DEBUG_EVENT  = 2;
  localparam int unsigned   PIN_TCK     = 3;
  localparam int unsigned   PIN_TDO     = 4;
  localparam int unsigned   PIN_TDI     = 5;
  localparam int unsigned   PIN_RST_REQ = 6;
  localparam int unsigned   PIN_MCU_DEBUG_EVENT  = 7;
  localparam logic [7:0]    ALT_IN_ONLY = 8'h6b;
  localparam logic [7:0]    PIN_OUT_RST = 8'h00;
  localparam logic [7:0]    PIN_OE_RST  = 8'h00;
  localparam logic [7:0]    PIN_SYNC_RST = 8'hff;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ASSERT  = 2'b01,
    ST_STRETCH = 2'b10
  } rbm_state_e;

endpackage : rbm_pkg

// ### pkg/rbm_qual_if.sv
// Link between a reset request pin and its qualifier
`timescale 1ns/1ps
interface rbm_qual_if;
  logic pin_b;
  logic req_valid;
  modport qual (input pin_b, output req_valid);
  modport mgr  (output pin_b, input req_valid);
endinterface : rbm_qual_if

// ### design/rbm_reset_qual.sv
// Reset request synchroniser and three-cycle qualifier
`timescale 1ns/1ps
module rbm_reset_qual (
  // Clock and reset
  input  wire logic    clk_in,
  input  wire logic    rst_b_in,
  // Request link
  rbm_qual_if.qual     q
);
  import rbm_pkg::*;

  logic [1:0] sync_ff;
  logic [1:0] nxt_sync;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic       valid_ff;
  logic       nxt_valid;
  logic       low;

  // ==========================================================
  // Qualifier
  always_comb begin
    nxt_sync  = {sync_ff[0], q.pin_b};
    low       = !sync_ff[1];
    nxt_cnt   = low ? ((cnt_ff == QUAL_CNT_MAX) ? cnt_ff : cnt_ff + 2'h1) : 2'h0;
    nxt_valid = low && (cnt_ff == QUAL_CNT_MAX);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_ff  <= SYNC_RST;
      cnt_ff   <= 2'h0;
      valid_ff <= 1'h0;
    end else begin
      sync_ff  <= nxt_sync;
      cnt_ff   <= nxt_cnt;
      valid_ff <= nxt_valid;
    end
  end

  assign q.req_valid = valid_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_qual_three_low: assert property (low [*3] |=> valid_ff)
    else $error("Three low samples did not qualify");
  a_qual_high_drop: assert property (!low |=> !valid_ff)
    else $error("Request valid without low sample");
  a_sync_two_stage: assert property ($rose(valid_ff) |->
      !$past(q.pin_b, 5) && !$past(q.pin_b, 4) && !$past(q.pin_b, 3))
    else $error("Request qualified without two-stage delay");

endmodule : rbm_reset_qual

// ### design/rbm_top.sv
// Reset sequencer, boot mode latch and shared pin bank select
// Functional notes
// - External reset request counts only after three consecutive low cycles.
// - System reset output goes low once a valid request is seen.
// - Reset output held during request, then seven more cycles after release.
// - Watchdog expiry drives reset output low for at least seven cycles.
// - With alternate bank, alternate request pin is qualified the same way.
// - Alternate bank takes reset request from the UART A RTS pin.
// - Boot source pin latched three cycles before reset output release.
// - Latched boot source high selects ROM boot, low selects flash.
// - Bank select swaps eight shared pins between normal and debug use.
// - Soft turn-off output keeps its level through sequenced resets.
`timescale 1ns/1ps
module rbm_top (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  // Reset sources and straps
  input  wire logic                    reset_req_b_in,
  input  wire logic                    pin_bank_select_in,
  input  wire logic                    boot_source_select_in,
  input  wire logic                    wdog_expire_in,
  // Reset and boot results
  output logic                         sys_rst_b_out,
  output logic                         boot_from_rom_out,
  // Shared pins
  input  wire logic [rbm_pkg::NPIN-1:0] shared_pin_in,
  output logic      [rbm_pkg::NPIN-1:0] shared_pin_out,
  output logic      [rbm_pkg::NPIN-1:0] shared_pin_oe_out,
  output logic      [rbm_pkg::NPIN-1:0] shared_pin_rx_out,
  // Normal pin functions
  input  wire logic [rbm_pkg::NPIN-1:0] norm_drive_in,
  input  wire logic [rbm_pkg::NPIN-1:0] norm_oe_in,
  // Alternate debug functions
  input  wire logic [rbm_pkg::NPIN-1:0] alt_drive_in,
  input  wire logic [rbm_pkg::NPIN-1:0] alt_oe_in,
  output logic                         alt_bank_active_out,
  // Soft turn-off output
  input  wire logic                    sto_load_in,
  input  wire logic                    sto_value_in,
  output logic                         soft_turn_off_output_out
);
  import rbm_pkg::*;

  rbm_qual_if prim_if ();
  rbm_qual_if alt_if ();

  rbm_state_e     state_ff;
  rbm_state_e     nxt_state;
  logic [2:0]     cnt_ff;
  logic [2:0]     nxt_cnt;
  logic           rst_out_ff;
  logic           nxt_rst_out;
  logic           boot_ff;
  logic           nxt_boot;
  logic [1:0]     boot_sync_ff;
  logic [1:0]     bank_sync_ff;
  logic           sto_ff;
  logic           nxt_sto;
  logic           req_sel;
  logic           boot_cap;
  logic [NPIN-1:0] psync1_ff;
  logic [NPIN-1:0] psync2_ff;
  logic [NPIN-1:0] pout_ff;
  logic [NPIN-1:0] poe_ff;
  logic [NPIN-1:0] nxt_pout;
  logic [NPIN-1:0] nxt_poe;

  // ==========================================================
  // Request qualifiers
  assign prim_if.pin_b = reset_req_b_in;
  assign alt_if.pin_b  = shared_pin_in[PIN_RST_REQ];

  rbm_reset_qual u_prim_qual (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .q        (prim_if.qual)
  );

  rbm_reset_qual u_alt_qual (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .q        (alt_if.qual)
  );

  // ==========================================================
  // Synchronisers for straps and bank select
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_sync_ff <= 2'h0;
      bank_sync_ff <= 2'h0;
    end else begin
      boot_sync_ff <= {boot_sync_ff[0], boot_source_select_in};
      bank_sync_ff <= {bank_sync_ff[0], pin_bank_select_in};
    end
  end

  // ==========================================================
  // Reset sequencer
  always_comb begin
    req_sel   = bank_sync_ff[1] ? alt_if.req_valid : prim_if.req_valid;
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (req_sel) begin
          nxt_state = ST_ASSERT;
        end else if (wdog_expire_in) begin
          nxt_state = ST_STRETCH;
          nxt_cnt   = STRETCH_CYC;
        end
      end
      ST_ASSERT: begin
        if (!req_sel) begin
          nxt_state = ST_STRETCH;
          nxt_cnt   = STRETCH_CYC;
        end
      end
      ST_STRETCH: begin
        if (req_sel) begin
          nxt_state = ST_ASSERT;
        end else if (wdog_expire_in) begin
          nxt_cnt = STRETCH_CYC;
        end else if (cnt_ff == CNT_LAST) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
      default: begin
        nxt_state = ST_STRETCH;
        nxt_cnt   = STRETCH_CYC;
      end
    endcase
    nxt_rst_out = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff   <= ST_STRETCH;
      cnt_ff     <= STRETCH_CYC;
      rst_out_ff <= 1'h0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      rst_out_ff <= nxt_rst_out;
    end
  end

  // ==========================================================
  // Boot mode latch
  always_comb begin
    boot_cap = (state_ff == ST_STRETCH) && (cnt_ff == BOOT_CAP_CNT) && !req_sel
               && !wdog_expire_in;
    nxt_boot = boot_cap ? boot_sync_ff[1] : boot_ff;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_ff <= BOOT_RST;
    end else begin
      boot_ff <= nxt_boot;
    end
  end

  // ==========================================================
  // Soft turn-off output, ignores sequenced resets
  always_comb begin
    nxt_sto = sto_load_in ? sto_value_in : sto_ff;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sto_ff <= STO_RST;
    end else begin
      sto_ff <= nxt_sto;
    end
  end

  // ==========================================================
  // Shared pin bank mux
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_comb begin
      if (bank_sync_ff[1]) begin
        nxt_pout[i] = alt_drive_in[i];
        nxt_poe[i]  = alt_oe_in[i] && !ALT_IN_ONLY[i];
      end else begin
        nxt_pout[i] = norm_drive_in[i];
        nxt_poe[i]  = norm_oe_in[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      psync1_ff <= PIN_SYNC_RST;
      psync2_ff <= PIN_SYNC_RST;
      pout_ff   <= PIN_OUT_RST;
      poe_ff    <= PIN_OE_RST;
    end else begin
      psync1_ff <= shared_pin_in;
      psync2_ff <= psync1_ff;
      pout_ff   <= nxt_pout;
      poe_ff    <= nxt_poe;
    end
  end

  // ==========================================================
  // Outputs
  assign sys_rst_b_out            = rst_out_ff;
  assign boot_from_rom_out        = boot_ff;
  assign shared_pin_out           = pout_ff;
  assign shared_pin_oe_out        = poe_ff;
  assign shared_pin_rx_out        = psync2_ff;
  assign alt_bank_active_out      = bank_sync_ff[1];
  assign soft_turn_off_output_out = sto_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_stretch7;
    (!rst_out_ff) [*7];
  endsequence

  a_rst_on_request: assert property ($rose(req_sel) |=> !rst_out_ff)
    else $error("Reset output not asserted on valid request");
  a_rst_held_req: assert property (req_sel |=> !rst_out_ff)
    else $error("Reset output released during request");
  a_rst_stretch_rel: assert property ($fell(req_sel) |=> s_stretch7)
    else $error("Reset output stretch after release too short");
  a_wdog_stretch: assert property (wdog_expire_in |=> s_stretch7)
    else $error("Watchdog reset shorter than seven cycles");
  a_alt_request: assert property (bank_sync_ff[1] && alt_if.req_valid |=> !rst_out_ff)
    else $error("Alternate request did not assert reset");
  a_boot_capture: assert property ($rose(rst_out_ff) |-> boot_ff == $past(boot_sync_ff[1], 4))
    else $error("Boot source not latched three cycles before release");
  a_boot_hold: assert property (!boot_cap |=> $stable(boot_ff))
    else $error("Boot mode changed outside capture");
  a_alt_in_only: assert property (bank_sync_ff[1] |=> (poe_ff & ALT_IN_ONLY) == 8'h00)
    else $error("Alternate input-only pin driven");
  a_sto_keep: assert property (!sto_load_in |=> $stable(sto_ff))
    else $error("Soft turn-off output changed without load");

endmodule : rbm_top

// ### verification/rbm_board_model.sv
// Board reset source, boot strap and debug converter model
`timescale 1ns/1ps
module rbm_board_model (
  // Clock
  input  wire logic       clk_in,
  // Board side pins
  output logic            reset_req_b_out,
  output logic            boot_source_select_out,
  output logic [7:0]      pin_drive_out
);
  // ==========================================================
  // Idle levels, debug controls inactive
  initial begin
    reset_req_b_out        = 1'h1;
    boot_source_select_out = 1'h0;
    pin_drive_out          = 8'hff;
  end

  // ==========================================================
  // Request held low for n sampled edges
  task automatic req_low(input logic alt, input int n);
    @(posedge clk_in);
    #1;
    pin_drive_out[6] = ~alt;
    reset_req_b_out  = alt;
    repeat (n) @(posedge clk_in);
    #1;
    pin_drive_out[6] = 1'h1;
    reset_req_b_out  = 1'h1;
  endtask : req_low

  // Strap level
  task automatic set_strap(input logic v);
    @(posedge clk_in);
    #1;
    boot_source_select_out = v;
  endtask : set_strap

  // Pin levels, TRST, TMS and request kept inactive
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_in);
    #1;
    pin_drive_out = v | 8'h43;
  endtask : set_pins
endmodule : rbm_board_model

// ### verification/rbm_top_bench.sv
// Self-checking bench for the reset, boot and pin bank block
`timescale 1ns/1ps
module rbm_top_bench;
  import rbm_pkg::*;
  logic       clk = 1'h0;
  logic       rst_b, bank, strap, req_b, wdog, sys_b, boot, alt_act;
  logic       sto_load, sto_val, soft_turn_off_output;
  logic [7:0] pin_in, pin_out, pin_oe, pin_rx, drv;
  logic [7:0] norm_drv, norm_oe, alt_drv, alt_oe, eo, ee;
  int         bad_count, num_checks, cyc, low_cnt, n;
  int         exp_len[$];
  logic       exp_boot[$];
  logic       v;
  logic       sto_exp;

  always #2 clk = ~clk;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);

  rbm_board_model u_board (.clk_in(clk), .reset_req_b_out(req_b),
    .boot_source_select_out(strap), .pin_drive_out(drv));

  rbm_top u_dut (.clk_in(clk), .rst_b_in(rst_b), .reset_req_b_in(req_b),
    .pin_bank_select_in(bank), .boot_source_select_in(strap), .wdog_expire_in(wdog),
    .sys_rst_b_out(sys_b), .boot_from_rom_out(boot), .shared_pin_in(pin_in),
    .shared_pin_out(pin_out), .shared_pin_oe_out(pin_oe), .shared_pin_rx_out(pin_rx),
    .norm_drive_in(norm_drv), .norm_oe_in(norm_oe), .alt_drive_in(alt_drv),
    .alt_oe_in(alt_oe), .alt_bank_active_out(alt_act), .sto_load_in(sto_load),
    .sto_value_in(sto_val), .soft_turn_off_output_out(soft_turn_off_output));

  // ==========================================================
  // Compare and report
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // ==========================================================
  // Reset pulse monitor, length in low cycles and boot source
  always @(negedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
    if (!rst_b) low_cnt = 0;
    else if (sys_b === 1'h0) low_cnt++;
    else if (low_cnt != 0) begin
      if (exp_len.size() == 0) check("reset_event", 0, low_cnt);
      else begin
        check("reset_len", exp_len.pop_front(), low_cnt);
        check("boot_src", exp_boot.pop_front(), boot);
      end
      low_cnt = 0;
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    rst_b    = 1'h0;
    bank     = 1'h0;
    wdog     = 1'h0;
    sto_load = 1'h0;
    sto_val  = 1'h0;
    norm_drv = 8'h00;
    norm_oe  = 8'h00;
    alt_drv  = 8'h00;
    alt_oe   = 8'h00;
    void'($urandom(22960));
    exp_len.push_back(7);
    exp_boot.push_back(1'h0);
    repeat (20) @(posedge clk);
    #1 rst_b = 1'h1;
    repeat (12) @(posedge clk);
    #1 sto_exp = 1'($urandom);
    sto_val  = sto_exp;
    sto_load = 1'h1;
    @(posedge clk);
    #1 sto_load = 1'h0;
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 3 : 3 + $urandom_range(7);
      v = 1'($urandom_range(1));
      u_board.set_strap(v);
      repeat (8) @(posedge clk);
      exp_len.push_back(n + 5);
      exp_boot.push_back(v);
      u_board.req_low(1'h0, n);
      repeat (20) @(posedge clk);
    end
    u_board.req_low(1'h0, 2);
    u_board.req_low(1'h1, 4);
    u_board.set_strap(1'h1);
    repeat (10) @(posedge clk);
    #1 wdog = 1'h1;
    exp_len.push_back(7);
    exp_boot.push_back(1'h1);
    @(posedge clk);
    #1 wdog = 1'h0;
    repeat (4) @(posedge clk);
    u_board.set_strap(1'h0);
    repeat (12) @(posedge clk);
    check("sto", sto_exp, soft_turn_off_output);
    // Watchdog reload during stretch
    #1 wdog = 1'h1;
    exp_len.push_back(10);
    exp_boot.push_back(1'h0);
    @(posedge clk);
    #1 wdog = 1'h0;
    repeat (2) @(posedge clk);
    #1 wdog = 1'h1;
    @(posedge clk);
    #1 wdog = 1'h0;
    sto_exp  = ~sto_exp;
    sto_val  = sto_exp;
    sto_load = 1'h1;
    @(posedge clk);
    #1 sto_load = 1'h0;
    repeat (15) @(posedge clk);
    for (int b = 0; b < 2; b++) begin
      #1 bank = b[0];
      repeat (6) @(posedge clk);
      check("bank_act", b, alt_act);
      for (int k = 0; k < 3; k++) begin
        #1 norm_drv = 8'($urandom);
        alt_drv  = 8'($urandom);
        alt_oe   = 8'($urandom);
        norm_oe  = 8'($urandom) & 8'hbc;
        u_board.set_pins(8'($urandom));
        repeat (5) @(posedge clk);
        eo = b ? alt_drv : norm_drv;
        ee = b ? (alt_oe & ~ALT_IN_ONLY) : norm_oe;
        check("pin_out", eo, pin_out);
        check("pin_oe", ee, pin_oe);
        check("pin_rx", (ee & eo) | (~ee & drv), pin_rx);
      end
    end
    exp_len.push_back(9);
    exp_boot.push_back(1'h0);
    u_board.req_low(1'h1, 4);
    repeat (20) @(posedge clk);
    u_board.req_low(1'h0, 4);
    repeat (20) @(posedge clk);
    check("pending", 0, exp_len.size());
    check("sto", sto_exp, soft_turn_off_output);
    // Second power-on reset in mid-run
    u_board.set_strap(1'h1);
    repeat (8) @(posedge clk);
    #1 rst_b = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    check("rst_sys", 0, sys_b);
    check("rst_oe", PIN_OE_RST, pin_oe);
    check("rst_out", PIN_OUT_RST, pin_out);
    check("rst_rx", PIN_SYNC_RST, pin_rx);
    check("rst_bank", 0, alt_act);
    check("rst_boot", BOOT_RST, boot);
    check("rst_sto", STO_RST, soft_turn_off_output);
    exp_len.push_back(7);
    exp_boot.push_back(1'h1);
    rst_b = 1'h1;
    repeat (20) @(posedge clk);
    check("pending", 0, exp_len.size());
    summarize();
  end
endmodule : rbm_top_bench
